// >>> rtl/dma_channel_defs.vh
// register offsets, field positions, codes and reset values of the dma channel
`ifndef DMA_CHANNEL_DEFS_VH
`define DMA_CHANNEL_DEFS_VH

// register byte offsets
`define OFF_TRANSFER_COUNT 12'h04c
`define OFF_CONTROL 12'h050
`define OFF_SOURCE_POINTER 12'h054
`define OFF_STATUS 12'h060
`define OFF_IRQ_MASK 12'h064

// control field positions
`define CTL_GO_BIT 0
`define CTL_REARM_BIT 1
`define CTL_SRC_LSB 4
`define CTL_SRC_MSB 7
`define CTL_DST_LSB 8
`define CTL_DST_MSB 11
`define CTL_WIDTH_BIT 12

// field widths
`define COUNT_W 18
`define PTR_W 19

// status bit positions
`define ST_DONE_BIT 0
`define ST_ERROR_BIT 1
`define ST_ABORT_BIT 2
`define ST_BUSY_BIT 8

// reset values
`define RST_COUNT 18'h00000
`define RST_PTR 19'h00000
`define RST_SEL 4'h0
`define RST_FLAGS 3'h0

// destination codes
`define DST_MEMORY 4'h0
`define DST_BBRAM 4'h1
`define DST_MODEM 4'h2
`define DST_UART0 4'h3
`define DST_I2S_DAC 4'h5
`define DST_SDMMC 4'h6
`define DST_SD1 4'h7
`define DST_UART1 4'h8
`define DST_SPI1 4'h9
`define DST_LCD 4'hc
`define DST_SPI0 4'hd

// source codes
`define SRC_MEMORY 4'h0
`define SRC_BBRAM 4'h1
`define SRC_UART0 4'h3
`define SRC_MODEM 4'h4
`define SRC_ADC 4'h5
`define SRC_SDMMC 4'h6
`define SRC_SD1 4'h7
`define SRC_UART1 4'h8
`define SRC_SPI1 4'h9
`define SRC_I2S 4'ha
`define SRC_SPI0 4'hd

// access width codes
`define WID_8 2'h0
`define WID_16 2'h1
`define WID_24 2'h2
`define WID_32 2'h3

`endif

// >>> rtl/dma_access_counter.v
// access counter of the dma channel: counts progress against the latched count
`timescale 1ns/1ps
`default_nettype none
`include "dma_channel_defs.vh"

module dma_access_counter (
  input wire pclk,
  input wire presetn,
  input wire load,
  input wire [`COUNT_W-1:0] limit,
  input wire advance,
  input wire [2:0] step,
  output reg [`COUNT_W-1:0] count_reg,
  output wire last
);

  wire [`COUNT_W:0] sum; // one bit wider so the compare cannot wrap

  assign sum = {1'b0, count_reg} + {16'h0000, step};
  // the last access may move fewer bytes than a full step; it still ends the run
  assign last = (sum >= {1'b0, limit});

  // cleared on every launch, stepped on every finished access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= `RST_COUNT;
    end else if (load) begin
      count_reg <= `RST_COUNT;
    end else if (advance) begin
      count_reg <= sum[`COUNT_W-1:0];
    end
  end

endmodule
`default_nettype wire

// >>> rtl/dma_channel_config.v
// configuration, control and sequencing of one dma channel behind an apb slave
//
// Contract
// - fifo destinations count fifo write operations
// - fifo sources count fifo read operations
// - other selections count bytes moved
// - width bit picks 16/24 for audio
// - width bit picks 8/32 for spi1
// - destination field decoding, reserved codes rejected
// - source field decoding, reserved codes rejected
// - auto-rearm relaunches after completion
// - go rising edge latches config, starts
// - go clears itself on error, and on completion when rearm is off
// - writing go zero aborts the transfer
// - pointer bit 0 ignored at 16 bits
// - pointer bits 1:0 ignored at 32 bits
`timescale 1ns/1ps
`default_nettype none
`include "dma_channel_defs.vh"

module dma_channel_config (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire request_line,
  input wire access_done,
  input wire access_error,
  output wire access_req,
  output reg [1:0] access_width,
  output wire [`PTR_W-1:0] access_src_addr,
  output reg [3:0] access_src_sel,
  output reg [3:0] access_dst_sel,
  output reg count_fifo_ops,
  output wire channel_busy,
  output wire irq
);

  localparam ST_IDLE = 1'b0; // waiting for go
  localparam ST_RUN = 1'b1; // transfer in progress

  // programmed registers
  reg [`COUNT_W-1:0] transfer_count_reg; // programmed count
  reg [`PTR_W-1:0] source_pointer_reg; // programmed source pointer
  reg [3:0] destination_select_reg; // programmed destination
  reg [3:0] source_select_reg; // programmed source
  reg sample_width_reg; // programmed width bit
  reg rearm_reg; // auto-rearm enable
  reg channel_go_reg; // go bit as software sees it
  reg [2:0] status_reg; // sticky done, error, abort
  reg [2:0] irq_mask_reg; // interrupt enables, same layout

  // engine state
  reg state_reg;
  reg state_next;
  reg [`COUNT_W-1:0] run_count_reg; // count latched at launch
  reg [`PTR_W-1:0] run_addr_reg; // running source address
  reg [`PTR_W-1:0] run_addr_next;
  reg [2:0] run_step_reg; // bytes per access of this run

  // apb decode
  wire setup_phase;
  wire wr_access;
  wire addr_hit;
  wire wr_control;
  wire go_rise;
  wire go_abort;
  wire launch;
  wire sel_bad;
  wire finish_ok;
  wire finish_err;
  wire last_access;
  wire counter_advance;
  wire [2:0] counter_step;
  wire [1:0] width_now;
  wire [2:0] status_set;
  reg [2:0] status_next;
  reg go_next;

  // decode of the width code from selections and the width bit
  function [1:0] width_of;
    input [3:0] dst;
    input [3:0] src;
    input wbit;
    begin
      if (dst == `DST_I2S_DAC || src == `SRC_I2S) begin
        width_of = wbit ? `WID_24 : `WID_16;
      end else if (dst == `DST_SPI1 || src == `SRC_SPI1) begin
        width_of = wbit ? `WID_32 : `WID_8;
      end else if (dst == `DST_UART0 || dst == `DST_UART1 || src == `SRC_UART0 || src == `SRC_UART1) begin
        width_of = `WID_8; // uarts move single bytes
      end else begin
        width_of = `WID_32;
      end
    end
  endfunction

  // byte size of one access for a width code
  function [2:0] bytes_of;
    input [1:0] wid;
    begin
      case (wid)
        `WID_8: bytes_of = 3'h1;
        `WID_16: bytes_of = 3'h2;
        default: bytes_of = 3'h4; // 24-bit samples occupy a full word
      endcase
    end
  endfunction

  // true when the count is a number of fifo operations
  function fifo_counted;
    input [3:0] dst;
    input [3:0] src;
    begin
      fifo_counted = (dst == `DST_LCD) || (dst == `DST_I2S_DAC) || (dst == `DST_SPI1) ||
                     (dst == `DST_SPI0) || (dst == `DST_MODEM) ||
                     (src == `SRC_ADC) || (src == `SRC_SPI1) || (src == `SRC_SPI0) ||
                     (src == `SRC_MODEM);
    end
  endfunction

  // destination code is one of the mapped ends
  function dst_valid;
    input [3:0] dst;
    begin
      case (dst)
        `DST_MEMORY, `DST_BBRAM, `DST_MODEM, `DST_UART0, `DST_I2S_DAC, `DST_SDMMC,
        `DST_SD1, `DST_UART1, `DST_SPI1, `DST_LCD, `DST_SPI0: dst_valid = 1'b1;
        default: dst_valid = 1'b0;
      endcase
    end
  endfunction

  // source code is one of the mapped ends
  function src_valid;
    input [3:0] src;
    begin
      case (src)
        `SRC_MEMORY, `SRC_BBRAM, `SRC_UART0, `SRC_MODEM, `SRC_ADC, `SRC_SDMMC,
        `SRC_SD1, `SRC_UART1, `SRC_SPI1, `SRC_I2S, `SRC_SPI0: src_valid = 1'b1;
        default: src_valid = 1'b0;
      endcase
    end
  endfunction

  // true for ends that are plain memory and need no request line
  function is_mem;
    input [3:0] code;
    begin
      is_mem = (code == 4'h0) || (code == 4'h1);
    end
  endfunction

  // mask the low pointer bits that a wide access cannot use
  function [`PTR_W-1:0] align_ptr;
    input [`PTR_W-1:0] ptr;
    input [1:0] wid;
    begin
      case (wid)
        `WID_16: align_ptr = {ptr[`PTR_W-1:1], 1'b0};
        `WID_32: align_ptr = {ptr[`PTR_W-1:2], 2'b00};
        default: align_ptr = ptr;
      endcase
    end
  endfunction

  assign pready = 1'b1; // every access completes without wait states
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign addr_hit = (paddr == `OFF_TRANSFER_COUNT) || (paddr == `OFF_CONTROL) ||
                    (paddr == `OFF_SOURCE_POINTER) || (paddr == `OFF_STATUS) || (paddr == `OFF_IRQ_MASK);
  assign pslverr = psel && penable && !addr_hit; // unmapped offsets answer with an error
  assign wr_control = wr_access && (paddr == `OFF_CONTROL);

  assign go_rise = wr_control && pwdata[`CTL_GO_BIT] && !channel_go_reg;
  assign go_abort = wr_control && !pwdata[`CTL_GO_BIT] && (state_reg == ST_RUN);
  // the launch uses the selections written in the same access
  assign width_now = width_of(pwdata[`CTL_DST_MSB:`CTL_DST_LSB], pwdata[`CTL_SRC_MSB:`CTL_SRC_LSB],
                              pwdata[`CTL_WIDTH_BIT]);
  assign sel_bad = !dst_valid(pwdata[`CTL_DST_MSB:`CTL_DST_LSB]) || !src_valid(pwdata[`CTL_SRC_MSB:`CTL_SRC_LSB]);
  assign launch = go_rise && !sel_bad;

  assign access_req = (state_reg == ST_RUN) && !go_abort &&
                      (request_line || (is_mem(access_src_sel) && is_mem(access_dst_sel)));
  assign counter_advance = (state_reg == ST_RUN) && access_done && !go_abort;
  assign counter_step = count_fifo_ops ? 3'h1 : run_step_reg;
  assign finish_ok = counter_advance && last_access && !access_error;
  assign finish_err = ((state_reg == ST_RUN) && access_error && !go_abort) || (go_rise && sel_bad);
  assign access_src_addr = run_addr_reg;
  assign channel_busy = (state_reg == ST_RUN);

  dma_access_counter u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .load(launch || (finish_ok && rearm_reg)),
    .limit(run_count_reg),
    .advance(counter_advance),
    .step(counter_step),
    .count_reg(),
    .last(last_access)
  );

  // engine sequencing and next address
  always @* begin
    state_next = state_reg;
    run_addr_next = run_addr_reg;
    case (state_reg)
      ST_IDLE: begin
        if (launch) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (go_abort || finish_err) begin
          state_next = ST_IDLE;
        end else if (finish_ok) begin
          if (rearm_reg) begin
            state_next = ST_RUN;
            run_addr_next = align_ptr(source_pointer_reg, access_width);
          end else begin
            state_next = ST_IDLE;
          end
        end else if (counter_advance && is_mem(access_src_sel)) begin
          run_addr_next = run_addr_reg + {16'h0000, run_step_reg}; // fifo sources keep one address
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // engine registers; a launch latches the configuration except the rearm bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      run_count_reg <= `RST_COUNT;
      run_addr_reg <= `RST_PTR;
      run_step_reg <= 3'h4;
      access_width <= `WID_32;
      access_src_sel <= `RST_SEL;
      access_dst_sel <= `RST_SEL;
      count_fifo_ops <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (launch) begin
        run_count_reg <= transfer_count_reg;
        run_addr_reg <= align_ptr(source_pointer_reg, width_now);
        run_step_reg <= bytes_of(width_now);
        access_width <= width_now;
        access_src_sel <= pwdata[`CTL_SRC_MSB:`CTL_SRC_LSB];
        access_dst_sel <= pwdata[`CTL_DST_MSB:`CTL_DST_LSB];
        count_fifo_ops <= fifo_counted(pwdata[`CTL_DST_MSB:`CTL_DST_LSB], pwdata[`CTL_SRC_MSB:`CTL_SRC_LSB]);
      end else if (finish_ok && rearm_reg) begin
        run_count_reg <= transfer_count_reg;
        run_addr_reg <= run_addr_next;
      end else begin
        run_addr_reg <= run_addr_next;
      end
    end
  end

  // go bit: written by software, dropped by the engine at the end
  always @* begin
    go_next = channel_go_reg;
    if (wr_control) begin
      go_next = pwdata[`CTL_GO_BIT];
    end
    if (finish_err || (finish_ok && !rearm_reg)) begin
      go_next = 1'b0;
    end
  end

  // sticky events; a new event wins over a clear in the same cycle
  assign status_set = {go_abort, finish_err, finish_ok};
  always @* begin
    status_next = status_reg;
    if (wr_access && (paddr == `OFF_STATUS)) begin
      status_next = status_reg & ~pwdata[2:0];
    end
    status_next = status_next | status_set;
  end

  // software visible registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transfer_count_reg <= `RST_COUNT;
      source_pointer_reg <= `RST_PTR;
      destination_select_reg <= `RST_SEL;
      source_select_reg <= `RST_SEL;
      sample_width_reg <= 1'b0;
      rearm_reg <= 1'b0;
      channel_go_reg <= 1'b0;
      status_reg <= `RST_FLAGS;
      irq_mask_reg <= `RST_FLAGS;
    end else begin
      channel_go_reg <= go_next;
      status_reg <= status_next;
      if (wr_access && (paddr == `OFF_TRANSFER_COUNT)) begin
        transfer_count_reg <= pwdata[`COUNT_W-1:0];
      end
      if (wr_access && (paddr == `OFF_SOURCE_POINTER)) begin
        source_pointer_reg <= pwdata[`PTR_W-1:0];
      end
      if (wr_access && (paddr == `OFF_IRQ_MASK)) begin
        irq_mask_reg <= pwdata[2:0];
      end
      if (wr_control) begin
        destination_select_reg <= pwdata[`CTL_DST_MSB:`CTL_DST_LSB];
        source_select_reg <= pwdata[`CTL_SRC_MSB:`CTL_SRC_LSB];
        sample_width_reg <= pwdata[`CTL_WIDTH_BIT];
        rearm_reg <= pwdata[`CTL_REARM_BIT];
      end
    end
  end

  // read data is prepared in the setup cycle so it stands in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      case (paddr)
        `OFF_TRANSFER_COUNT: prdata <= {14'h0000, transfer_count_reg};
        `OFF_CONTROL: prdata <= {19'h00000, sample_width_reg, destination_select_reg,
                                 source_select_reg, 2'b00, rearm_reg, channel_go_reg};
        `OFF_SOURCE_POINTER: prdata <= {13'h0000, source_pointer_reg};
        `OFF_STATUS: prdata <= {23'h000000, channel_busy, 5'h00, status_reg};
        `OFF_IRQ_MASK: prdata <= {29'h00000000, irq_mask_reg};
        default: prdata <= 32'h00000000; // unmapped reads return zero
      endcase
    end
  end

  // one level interrupt while any enabled event is pending
  assign irq = |(status_reg & irq_mask_reg);

endmodule
`default_nettype wire

// >>> test/dma_channel_config_properties.sv
// checker: timing relations at the ports of the dma channel
`timescale 1ns/1ps
`default_nettype none
`include "dma_channel_defs.vh"
module dma_channel_config_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic request_line,
  input wire logic access_done,
  input wire logic access_error,
  input wire logic access_req,
  input wire logic [1:0] access_width,
  input wire logic [18:0] access_src_addr,
  input wire logic [3:0] access_src_sel,
  input wire logic [3:0] access_dst_sel,
  input wire logic count_fifo_ops,
  input wire logic channel_busy,
  input wire logic irq
);
  // control write in its access phase, and a launch from idle
  wire wr_ctl = psel && penable && pwrite && (paddr == `OFF_CONTROL);
  wire launch = wr_ctl && pwdata[0] && !channel_busy;
  // code decoders; i2s receive stays out of the fifo check, its counting is ambiguous
  function automatic logic dst_ok(input logic [3:0] c);
    return !(c == 4'h4 || c == 4'ha || c == 4'hb || c > 4'hd);
  endfunction
  function automatic logic src_ok(input logic [3:0] c);
    return !(c == 4'h2 || c == 4'hb || c == 4'hc || c > 4'hd);
  endfunction
  function automatic logic fifo_ops(input logic [3:0] d, input logic [3:0] s);
    return (d inside {4'h2, 4'h5, 4'h9, 4'hc, 4'hd}) || (s inside {4'h4, 4'h5, 4'h9, 4'hd});
  endfunction
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  launch_latch_a: assert property (launch && dst_ok(pwdata[11:8]) && src_ok(pwdata[7:4]) |=> channel_busy
    && access_dst_sel == $past(pwdata[11:8]) && access_src_sel == $past(pwdata[7:4])) else $error("launch lost");
  dst_reserved_a: assert property (launch && !dst_ok(pwdata[11:8]) |=> !channel_busy) else $error("bad dst ran");
  src_reserved_a: assert property (launch && !src_ok(pwdata[7:4]) |=> !channel_busy) else $error("bad src ran");
  count_kind_a: assert property (channel_busy && access_src_sel != 4'ha
    |-> count_fifo_ops == fifo_ops(access_dst_sel, access_src_sel)) else $error("count kind wrong");
  audio_width_a: assert property (channel_busy && access_dst_sel == `DST_I2S_DAC
    |-> access_width inside {`WID_16, `WID_24}) else $error("audio width wrong");
  spi_width_a: assert property (channel_busy && access_dst_sel == `DST_SPI1
    |-> access_width inside {`WID_8, `WID_32}) else $error("spi width wrong");
  half_align_a: assert property (channel_busy && access_width == `WID_16 |-> !access_src_addr[0])
    else $error("half address odd");
  word_align_a: assert property (channel_busy && access_width == `WID_32 |-> access_src_addr[1:0] == 2'h0)
    else $error("word address unaligned");
  error_stop_a: assert property (channel_busy && access_error |=> !channel_busy) else $error("error ignored");
  abort_stop_a: assert property (wr_ctl && !pwdata[0] && channel_busy |-> !access_req ##1 !channel_busy)
    else $error("abort ignored");
  idle_quiet_a: assert property (!channel_busy |-> !access_req) else $error("request while idle");
endmodule
bind dma_channel_config dma_channel_config_properties props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .request_line(request_line), .access_done(access_done), .access_error(access_error),
  .access_req(access_req), .access_width(access_width), .access_src_addr(access_src_addr),
  .access_src_sel(access_src_sel), .access_dst_sel(access_dst_sel), .count_fifo_ops(count_fifo_ops),
  .channel_busy(channel_busy), .irq(irq));
`default_nettype wire

// >>> test/fifo_partner.sv
// far-side model: a peripheral fifo or memory answering the channel's requests
`timescale 1ns/1ps
`default_nettype none
module fifo_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic access_req,
  input wire logic slow,
  input wire logic inject_err,
  output logic request_line,
  output logic access_done,
  output logic access_error
);
  logic [2:0] wait_cnt; // cycles before the fifo is ready again
  // one answer per standing request; a slow fifo drops its ready line while it recovers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_line <= 1'b0;
      access_done <= 1'b0;
      access_error <= 1'b0;
      wait_cnt <= 3'd0;
    end else begin
      access_done <= 1'b0;
      access_error <= 1'b0;
      request_line <= !(slow && wait_cnt != 3'd0);
      // no answer once the request is withdrawn, as after an abort
      if (access_req && !access_done && !access_error && wait_cnt == 3'd0) begin
        access_error <= inject_err;
        access_done <= !inject_err;
        wait_cnt <= slow ? 3'd4 : 3'd0;
      end else if (wait_cnt != 3'd0) begin
        wait_cnt <= wait_cnt - 3'd1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/test_dma_channel_config.sv
// self-checking bench: registers, counting, widths, abort, errors, reserved codes, rearm
`timescale 1ns/1ps
`default_nettype none
`include "dma_channel_defs.vh"
module test_dma_channel_config;
  logic pclk = 1'b0; // 200 MHz
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic slow = 1'b0; // partner pauses between answers when set
  logic inject = 1'b0; // partner fails its accesses when set
  wire [31:0] prdata;
  wire pready, pslverr, request_line, access_done, access_error, access_req, count_fifo_ops, channel_busy, irq;
  wire [1:0] access_width;
  wire [18:0] access_src_addr;
  wire [3:0] access_src_sel, access_dst_sel;
  int n_fail = 0;
  int tests_run = 0;
  int n_acc = 0; // finished accesses seen at the far side
  int cyc = 0;
  logic [31:0] r; // last read data
  logic e; // last error response
  dma_channel_config dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .request_line(request_line), .access_done(access_done), .access_error(access_error), .access_req(access_req),
    .access_width(access_width), .access_src_addr(access_src_addr), .access_src_sel(access_src_sel),
    .access_dst_sel(access_dst_sel), .count_fifo_ops(count_fifo_ops), .channel_busy(channel_busy), .irq(irq));
  fifo_partner far_i (.pclk(pclk), .presetn(presetn), .access_req(access_req), .slow(slow), .inject_err(inject),
    .request_line(request_line), .access_done(access_done), .access_error(access_error));
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (access_done === 1'b1) n_acc++;
  // hang guard: the whole run needs a few hundred cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] ctl(input logic [3:0] d, input logic [3:0] s, input logic w, rl, g);
    return {19'h0, w, d, s, 2'b00, rl, g};
  endfunction
  // launch and wait until the channel is idle again
  task automatic run(input logic [31:0] c, input logic [31:0] n);
    apb(`OFF_TRANSFER_COUNT, 1'b1, n);
    n_acc = 0;
    apb(`OFF_CONTROL, 1'b1, c);
    @(negedge pclk);
    while (channel_busy !== 1'b0) @(negedge pclk);
  endtask
  task automatic t_regs;
    logic [11:0] ad [4];
    logic [31:0] mk [4];
    ad = '{`OFF_TRANSFER_COUNT, `OFF_CONTROL, `OFF_SOURCE_POINTER, `OFF_IRQ_MASK};
    mk = '{32'h3fffe, 32'h1ff2, 32'h7fffe, 32'h6};
    for (int i = 0; i < 4; i++) begin
      apb(ad[i], 1'b0, 32'h0);
      chk(r, 32'h0);
      apb(ad[i], 1'b1, 32'hfffffffe);
      apb(ad[i], 1'b0, 32'h0);
      chk(r, mk[i]);
      chk({31'h0, e}, 32'h0);
    end
    apb(12'h010, 1'b0, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("t_regs finished");
  endtask
  task automatic t_counts;
    logic [31:0] tc [4];
    int nc [4];
    int ex [4];
    tc = '{ctl(`DST_SPI0, `SRC_MEMORY, 0, 0, 1), ctl(`DST_MEMORY, `SRC_ADC, 0, 0, 1),
      ctl(`DST_MEMORY, `SRC_MEMORY, 0, 0, 1), ctl(`DST_LCD, `SRC_MEMORY, 0, 0, 1)};
    nc = '{3, 3, 8, 2};
    ex = '{3, 3, 2, 2}; // words of four bytes between memories
    for (int i = 0; i < 4; i++) begin
      // clear the sticky bits first so each done below is a fresh event
      apb(`OFF_STATUS, 1'b1, 32'h7);
      run(tc[i], nc[i]);
      chk(n_acc, ex[i]);
      apb(`OFF_CONTROL, 1'b0, 32'h0);
      chk(r & 32'h1, 32'h0);
      apb(`OFF_STATUS, 1'b0, 32'h0);
      chk(r, 32'h1);
    end
    $display("t_counts finished");
  endtask
  task automatic t_irq;
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(`OFF_IRQ_MASK, 1'b1, 32'h7);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(`OFF_STATUS, 1'b1, 32'h7);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("t_irq finished");
  endtask
  task automatic t_widths;
    logic [3:0] wd [4];
    logic [1:0] wx [4];
    logic [18:0] ax;
    wd = '{`DST_I2S_DAC, `DST_I2S_DAC, `DST_SPI1, `DST_SPI1};
    wx = '{`WID_16, `WID_24, `WID_8, `WID_32};
    slow <= 1'b1;
    apb(`OFF_SOURCE_POINTER, 1'b1, 32'h7);
    apb(`OFF_TRANSFER_COUNT, 1'b1, 32'h3ffff);
    for (int i = 0; i < 4; i++) begin
      apb(`OFF_CONTROL, 1'b1, ctl(wd[i], `SRC_MEMORY, i[0], 1'b0, 1'b1));
      @(negedge pclk);
      chk(access_width, wx[i]);
      ax = (wx[i] == `WID_16) ? 19'h6 : (wx[i] == `WID_32) ? 19'h4 : 19'h7;
      if (wx[i] != `WID_24) chk(access_src_addr, ax);
      apb(`OFF_CONTROL, 1'b1, 32'h0);
      @(negedge pclk);
      chk(channel_busy, 1'b0);
      apb(`OFF_STATUS, 1'b0, 32'h0);
      chk(r & 32'h4, 32'h4);
      apb(`OFF_STATUS, 1'b1, 32'h7);
    end
    slow <= 1'b0;
    $display("t_widths finished");
  endtask
  task automatic t_error;
    inject <= 1'b1;
    run(ctl(`DST_SPI0, `SRC_MEMORY, 1'b0, 1'b0, 1'b1), 32'h5);
    inject <= 1'b0;
    chk(n_acc, 0);
    apb(`OFF_STATUS, 1'b0, 32'h0);
    chk(r, 32'h2);
    apb(`OFF_STATUS, 1'b1, 32'h7);
    $display("t_error finished");
  endtask
  task automatic t_reserved;
    for (int i = 0; i < 2; i++) begin
      apb(`OFF_CONTROL, 1'b1, i ? ctl(`DST_MEMORY, 4'h2, 0, 0, 1) : ctl(4'h4, `SRC_MEMORY, 0, 0, 1));
      @(negedge pclk);
      chk(channel_busy, 1'b0);
      apb(`OFF_STATUS, 1'b0, 32'h0);
      chk(r, 32'h2);
      apb(`OFF_STATUS, 1'b1, 32'h7);
      apb(`OFF_CONTROL, 1'b0, 32'h0);
      chk(r & 32'h1, 32'h0);
    end
    $display("t_reserved finished");
  endtask
  task automatic t_rearm;
    apb(`OFF_TRANSFER_COUNT, 1'b1, 32'h2);
    n_acc = 0;
    apb(`OFF_CONTROL, 1'b1, ctl(`DST_SPI0, `SRC_MEMORY, 1'b0, 1'b1, 1'b1));
    while (n_acc < 5) @(negedge pclk);
    chk(channel_busy, 1'b1);
    apb(`OFF_STATUS, 1'b0, 32'h0);
    chk(r & 32'h101, 32'h101);
    apb(`OFF_CONTROL, 1'b0, 32'h0);
    chk(r & 32'h1, 32'h1);
    apb(`OFF_CONTROL, 1'b1, 32'h0);
    $display("t_rearm finished");
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_counts;
    t_irq;
    t_widths;
    t_error;
    t_reserved;
    t_rearm;
    final_report;
  end
endmodule
`default_nettype wire
